// *** rtl/ir_codec_pkg.sv ***
/*
 * ir_codec_pkg: constants, types and timing for the infrared nibble
 * burst/gap codec.
 * assumes a single 50 MHz system clock; all times derive from it.
 */
package ir_codec_pkg;
	// system clock and carrier
	localparam int unsigned CLK_HZ = 50000000;
	localparam int unsigned CARRIER_HZ = 57600;
	// carrier period in clock cycles, rounded down (868)
	localparam int unsigned CARRIER_CLKS = CLK_HZ / CARRIER_HZ;
	localparam int unsigned HALF_CARRIER_CLKS = CARRIER_CLKS / 2;

	// nibble width and carrier-cycle counter width
	localparam int unsigned NIB_W = 4;
	localparam int unsigned CYC_W = 6;

	// burst lengths in carrier cycles, one per burst bin
	localparam logic [5:0] BURST_GRP0 = 6'h06;
	localparam logic [5:0] BURST_GRP1 = 6'h0c;
	localparam logic [5:0] BURST_GRP2 = 6'h12;
	localparam logic [5:0] BURST_GRP3 = 6'h18;
	// header burst and gap
	localparam logic [5:0] HDR_BURST = 6'h1e;
	localparam logic [5:0] HDR_GAP = 6'h0a;
	// first gap of every group and step between gaps
	localparam logic [5:0] GAP_BASE = 6'h0a;
	localparam logic [5:0] GAP_STEP = 6'h04;
	// first nibble of burst groups 1 to 3; group 0 starts at nibble 0
	localparam logic [3:0] GRP1_FIRST = 4'h6;
	localparam logic [3:0] GRP2_FIRST = 4'hb;
	localparam logic [3:0] GRP3_FIRST = 4'he;

	// decoder windows, in microseconds as printed
	localparam int unsigned BURST0_MIN_US = 87;
	localparam int unsigned BURST0_MAX_US = 174;
	localparam int unsigned BURST1_MIN_US = 191;
	localparam int unsigned BURST1_MAX_US = 278;
	localparam int unsigned BURST2_MIN_US = 295;
	localparam int unsigned BURST2_MAX_US = 382;
	localparam int unsigned BURST3_MIN_US = 399;
	localparam int unsigned BURST3_MAX_US = 486;
	// header burst accepted with the same -1/+4 cycle tolerance
	localparam int unsigned HDRB_MIN_US = 503;
	localparam int unsigned HDRB_MAX_US = 590;
	// gap windows, nominal +/- 1.9 carrier cycles
	localparam int unsigned GAP0_MIN_US = 141;
	localparam int unsigned GAP0_MAX_US = 207;
	localparam int unsigned GAP1_MIN_US = 210;
	localparam int unsigned GAP1_MAX_US = 276;
	localparam int unsigned GAP2_MIN_US = 280;
	localparam int unsigned GAP2_MAX_US = 345;
	localparam int unsigned GAP3_MIN_US = 349;
	localparam int unsigned GAP3_MAX_US = 415;
	localparam int unsigned GAP4_MIN_US = 418;
	localparam int unsigned GAP4_MAX_US = 484;
	localparam int unsigned GAP5_MIN_US = 488;
	localparam int unsigned GAP5_MAX_US = 554;
	// pulse trim ahead of a uart, 1.5 carrier cycles, in tenths
	localparam int unsigned TRIM_TENTHS = 15;

	// measurement counter width, enough for the longest gap time
	localparam int unsigned MEAS_W = 16;
	localparam int unsigned CLKS_PER_US = CLK_HZ / 1000000;

	// least and longest times both convert by the same exact multiply, no rounding
	function automatic logic [MEAS_W-1:0] us_min(input int unsigned us);
		us_min = MEAS_W'(us * CLKS_PER_US);
	endfunction
	function automatic logic [MEAS_W-1:0] us_max(input int unsigned us);
		us_max = MEAS_W'(us * CLKS_PER_US);
	endfunction

	localparam logic [MEAS_W-1:0] TRIM_CLKS =
		MEAS_W'((TRIM_TENTHS * CARRIER_CLKS) / 10);
	// gap long enough to mark end of transmission (past largest window)
	localparam logic [MEAS_W-1:0] IDLE_CLKS = us_max(GAP5_MAX_US + 100);

	// encoder states
	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_BURST = 2'b01,
		TX_GAP = 2'b10
	} tx_state_t;

	// decoder states
	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_BURST = 2'b01,
		RX_GAP = 2'b10
	} rx_state_t;

	// symbol on the encoder input: header request or data nibble
	typedef struct packed {
		logic header;
		logic [NIB_W-1:0] nibble;
	} tx_symbol_t;

	// decoded result
	typedef struct packed {
		logic header;
		logic [NIB_W-1:0] nibble;
	} rx_symbol_t;
endpackage

// *** rtl/ir_pulse_trim.sv ***
/*
 * ir_pulse_trim: shortens each low pulse of the receiver output by a
 * fixed number of clocks before it reaches a uart.
 * assumes rx input is synchronous to clk_sys and active low.
 */
`timescale 1ns/100ps
module ir_pulse_trim #(
	parameter logic [15:0] TRIM = ir_codec_pkg::TRIM_CLKS
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// raw and trimmed receiver levels, low is burst
	input wire logic rx_n,
	output logic trimmed_n
);
	// clocks since the current low pulse began, saturating
	logic [15:0] low_cnt_reg;
	logic [15:0] low_cnt_next;
	logic out_reg;
	wire in_low = !rx_n;
	wire past_trim = (low_cnt_reg >= TRIM);

	// count while low; restart on every high level
	assign low_cnt_next = !in_low ? 16'h0000 :
		(past_trim ? low_cnt_reg : low_cnt_reg + 16'h0001);

	// delaying only the falling edge trims width, rising edge untouched
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			low_cnt_reg <= 16'h0000;
			out_reg <= 1'b1;
		end else begin
			low_cnt_reg <= low_cnt_next;
			out_reg <= !(in_low && past_trim);
		end
	end
	// a pulse shorter than the trim vanishes entirely
	assign trimmed_n = out_reg;
endmodule

// *** rtl/ir_nibble_burst_gap_codec.sv ***
/*
 * ir_nibble_burst_gap_codec: encodes nibbles into carrier bursts and
 * gaps, decodes demodulated receiver output back into nibbles, and
 * provides a trimmed receiver level for a uart.
 * assumes one 50 MHz clock and receiver output synchronous to it.
 */
`timescale 1ns/100ps
module ir_nibble_burst_gap_codec #(
	parameter int unsigned CARRIER_CLKS = ir_codec_pkg::CARRIER_CLKS
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// transmit symbol stream
	input wire ir_codec_pkg::tx_symbol_t tx_symbol,
	input wire logic tx_valid,
	output logic tx_ready,
	// emitter drive, carrier-modulated, high lights the led
	output logic ir_tx,
	// demodulated receiver output, low during a burst
	input wire logic ir_rx_n,
	// decoded symbol stream
	output ir_codec_pkg::rx_symbol_t rx_symbol,
	output logic rx_valid,
	output logic rx_frame_err,
	// receiver level trimmed for a direct uart connection
	output logic uart_rx_n
);
	// carrier divider: one-cycle enable in the last clock of each carrier period
	logic [15:0] car_cnt_reg;
	wire car_tick = (car_cnt_reg == 16'(CARRIER_CLKS - 1));
	wire car_high = (car_cnt_reg < 16'(CARRIER_CLKS / 2));

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			car_cnt_reg <= 16'h0000;
		end else begin
			car_cnt_reg <= car_tick ? 16'h0000 : car_cnt_reg + 16'h0001;
		end
	end

	// burst length for a nibble by group
	function automatic logic [5:0] burst_len(input logic [3:0] n);
		if (n < ir_codec_pkg::GRP1_FIRST) begin
			burst_len = ir_codec_pkg::BURST_GRP0;
		end else if (n < ir_codec_pkg::GRP2_FIRST) begin
			burst_len = ir_codec_pkg::BURST_GRP1;
		end else if (n < ir_codec_pkg::GRP3_FIRST) begin
			burst_len = ir_codec_pkg::BURST_GRP2;
		end else begin
			burst_len = ir_codec_pkg::BURST_GRP3;
		end
	endfunction

	// first nibble of a nibble's group
	function automatic logic [3:0] grp_first(input logic [3:0] n);
		if (n < ir_codec_pkg::GRP1_FIRST) begin
			grp_first = 4'h0;
		end else if (n < ir_codec_pkg::GRP2_FIRST) begin
			grp_first = ir_codec_pkg::GRP1_FIRST;
		end else if (n < ir_codec_pkg::GRP3_FIRST) begin
			grp_first = ir_codec_pkg::GRP2_FIRST;
		end else begin
			grp_first = ir_codec_pkg::GRP3_FIRST;
		end
	endfunction

	// encoder
	ir_codec_pkg::tx_state_t tx_state_reg;
	ir_codec_pkg::tx_state_t tx_state_next;
	logic [5:0] tx_left_reg; // carrier cycles left in this phase
	logic [5:0] tx_left_next;
	logic [5:0] tx_gap_reg; // gap length held for the gap phase
	logic ir_tx_reg;

	// symbol lengths; only accepted on a carrier boundary
	wire [3:0] tx_nib = tx_symbol.nibble;
	wire [3:0] tx_idx = tx_nib - grp_first(tx_nib);
	wire [5:0] tx_burst = tx_symbol.header ? ir_codec_pkg::HDR_BURST :
		burst_len(tx_nib);
	wire [5:0] tx_gap = tx_symbol.header ? ir_codec_pkg::HDR_GAP :
		6'(ir_codec_pkg::GAP_BASE +
		ir_codec_pkg::GAP_STEP * {2'b00, tx_idx});
	wire tx_take = tx_valid && tx_ready;
	wire tx_last = (tx_left_reg == 6'h01);

	// symbols only start at a carrier boundary so the burst is whole
	assign tx_ready = car_tick && ((tx_state_reg == ir_codec_pkg::TX_IDLE) ||
		(tx_state_reg == ir_codec_pkg::TX_GAP && tx_last));

	// next-state: burst phase then gap phase per symbol
	always_comb begin
		tx_state_next = tx_state_reg;
		tx_left_next = tx_left_reg;
		case (tx_state_reg)
			ir_codec_pkg::TX_IDLE: begin
				if (tx_take) begin
					tx_state_next = ir_codec_pkg::TX_BURST;
					tx_left_next = tx_burst;
				end
			end
			ir_codec_pkg::TX_BURST: begin
				if (car_tick) begin
					tx_left_next = tx_left_reg - 6'h01;
					if (tx_last) begin
						tx_state_next = ir_codec_pkg::TX_GAP;
						tx_left_next = tx_gap_reg;
					end
				end
			end
			ir_codec_pkg::TX_GAP: begin
				if (car_tick) begin
					tx_left_next = tx_left_reg - 6'h01;
					if (tx_take) begin
						// back to back symbol
						tx_state_next = ir_codec_pkg::TX_BURST;
						tx_left_next = tx_burst;
					end else if (tx_last) begin
						tx_state_next = ir_codec_pkg::TX_IDLE;
					end
				end
			end
			default: begin
				tx_state_next = ir_codec_pkg::TX_IDLE;
			end
		endcase
	end

	// encoder registers; emitter is registered to stay glitch free
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tx_state_reg <= ir_codec_pkg::TX_IDLE;
			tx_left_reg <= 6'h00;
			tx_gap_reg <= 6'h00;
			ir_tx_reg <= 1'b0;
		end else begin
			tx_state_reg <= tx_state_next;
			tx_left_reg <= tx_left_next;
			if (tx_take) begin
				tx_gap_reg <= tx_gap;
			end
			// carrier only in burst; off through gap and idle
			ir_tx_reg <= (tx_state_next == ir_codec_pkg::TX_BURST) &&
				(tx_take || car_tick ? 1'b1 : car_high);
		end
	end
	assign ir_tx = ir_tx_reg;

	// decoder
	ir_codec_pkg::rx_state_t rx_state_reg;
	ir_codec_pkg::rx_state_t rx_state_next;
	logic [ir_codec_pkg::MEAS_W-1:0] meas_reg; // clocks in this level
	logic [2:0] bbin_reg; // burst bin: 0..3 data, 4 header
	logic rx_low_reg; // previous level, for edges
	ir_codec_pkg::rx_symbol_t rx_symbol_reg;
	logic rx_valid_reg;
	logic rx_err_reg;

	// a low level is a burst, high is idle or gap
	wire rx_low = !ir_rx_n;
	wire fall = rx_low && !rx_low_reg;
	wire rise = !rx_low && rx_low_reg;

	// window test: measured length inside [lo, hi] microseconds
	function automatic logic in_win(input logic [15:0] m,
		input int unsigned lo, input int unsigned hi);
		in_win = (m >= ir_codec_pkg::us_min(lo)) &&
			(m <= ir_codec_pkg::us_max(hi));
	endfunction

	// burst bins, windows span -1/+4 carrier cycles, covering jitter
	wire b0 = in_win(meas_reg, ir_codec_pkg::BURST0_MIN_US,
		ir_codec_pkg::BURST0_MAX_US);
	wire b1 = in_win(meas_reg, ir_codec_pkg::BURST1_MIN_US,
		ir_codec_pkg::BURST1_MAX_US);
	wire b2 = in_win(meas_reg, ir_codec_pkg::BURST2_MIN_US,
		ir_codec_pkg::BURST2_MAX_US);
	wire b3 = in_win(meas_reg, ir_codec_pkg::BURST3_MIN_US,
		ir_codec_pkg::BURST3_MAX_US);
	wire bh = in_win(meas_reg, ir_codec_pkg::HDRB_MIN_US,
		ir_codec_pkg::HDRB_MAX_US);
	wire [2:0] bbin_new = b0 ? 3'h0 : b1 ? 3'h1 : b2 ? 3'h2 :
		b3 ? 3'h3 : 3'h4;
	wire burst_ok = b0 | b1 | b2 | b3 | bh;

	// gap bins at +/-1.9 cycles, dead zones between them
	wire [5:0] gwin;
	assign gwin[0] = in_win(meas_reg, ir_codec_pkg::GAP0_MIN_US,
		ir_codec_pkg::GAP0_MAX_US);
	assign gwin[1] = in_win(meas_reg, ir_codec_pkg::GAP1_MIN_US,
		ir_codec_pkg::GAP1_MAX_US);
	assign gwin[2] = in_win(meas_reg, ir_codec_pkg::GAP2_MIN_US,
		ir_codec_pkg::GAP2_MAX_US);
	assign gwin[3] = in_win(meas_reg, ir_codec_pkg::GAP3_MIN_US,
		ir_codec_pkg::GAP3_MAX_US);
	assign gwin[4] = in_win(meas_reg, ir_codec_pkg::GAP4_MIN_US,
		ir_codec_pkg::GAP4_MAX_US);
	assign gwin[5] = in_win(meas_reg, ir_codec_pkg::GAP5_MIN_US,
		ir_codec_pkg::GAP5_MAX_US);
	wire [2:0] gbin = gwin[0] ? 3'h0 : gwin[1] ? 3'h1 : gwin[2] ? 3'h2 :
		gwin[3] ? 3'h3 : gwin[4] ? 3'h4 : 3'h5;

	// groups hold 6, 5, 3, 2 gap values; higher gap bins are illegal
	wire [2:0] gmax = (bbin_reg == 3'h0) ? 3'h5 : (bbin_reg == 3'h1) ?
		3'h4 : (bbin_reg == 3'h2) ? 3'h2 : (bbin_reg == 3'h3) ? 3'h1 :
		3'h0;
	wire gap_ok = (|gwin) && (gbin <= gmax);
	wire [3:0] grp_base = (bbin_reg == 3'h0) ? 4'h0 :
		(bbin_reg == 3'h1) ? ir_codec_pkg::GRP1_FIRST :
		(bbin_reg == 3'h2) ? ir_codec_pkg::GRP2_FIRST :
		ir_codec_pkg::GRP3_FIRST;
	wire [3:0] dec_nib = grp_base + {1'b0, gbin};
	// a gap ends at the next fall, or when it runs past every window
	wire gap_end = fall ||
		(!rx_low && meas_reg >= ir_codec_pkg::IDLE_CLKS);
	wire is_hdr = (bbin_reg == 3'h4);

	// decoder sequencing: idle, time burst, time gap
	always_comb begin
		rx_state_next = rx_state_reg;
		case (rx_state_reg)
			ir_codec_pkg::RX_IDLE: begin
				if (fall) begin
					rx_state_next = ir_codec_pkg::RX_BURST;
				end
			end
			ir_codec_pkg::RX_BURST: begin
				if (rise) begin
					// bad burst drops the symbol
					rx_state_next = burst_ok ? ir_codec_pkg::RX_GAP :
						ir_codec_pkg::RX_IDLE;
				end
			end
			ir_codec_pkg::RX_GAP: begin
				if (gap_end) begin
					rx_state_next = fall ? ir_codec_pkg::RX_BURST :
						ir_codec_pkg::RX_IDLE;
				end
			end
			default: begin
				rx_state_next = ir_codec_pkg::RX_IDLE;
			end
		endcase
	end

	// measurement counter restarts at each edge and saturates
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			meas_reg <= '0;
			rx_low_reg <= 1'b0;
		end else begin
			rx_low_reg <= rx_low;
			if (fall || rise) begin
				meas_reg <= 16'h0001;
			end else if (meas_reg != 16'hffff) begin
				meas_reg <= meas_reg + 16'h0001;
			end
		end
	end

	// bin capture and result outputs; valid and error are pulses
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rx_state_reg <= ir_codec_pkg::RX_IDLE;
			bbin_reg <= 3'h0;
			rx_symbol_reg <= '0;
			rx_valid_reg <= 1'b0;
			rx_err_reg <= 1'b0;
		end else begin
			rx_state_reg <= rx_state_next;
			rx_valid_reg <= 1'b0;
			rx_err_reg <= 1'b0;
			if (rx_state_reg == ir_codec_pkg::RX_BURST && rise) begin
				bbin_reg <= bbin_new;
				rx_err_reg <= !burst_ok;
			end
			if (rx_state_reg == ir_codec_pkg::RX_GAP && gap_end) begin
				// header gap must match the header's 10-cycle bin
				if (is_hdr ? gwin[0] : gap_ok) begin
					rx_valid_reg <= 1'b1;
					rx_symbol_reg.header <= is_hdr;
					rx_symbol_reg.nibble <= is_hdr ? 4'h0 : dec_nib;
				end else begin
					rx_err_reg <= 1'b1;
				end
			end
		end
	end
	assign rx_symbol = rx_symbol_reg;
	assign rx_valid = rx_valid_reg;
	assign rx_frame_err = rx_err_reg;

	// uart path: trimmed so mid-bit sampling at 8 of 16 stays clean
	ir_pulse_trim #(
		.TRIM(ir_codec_pkg::TRIM_CLKS)
	) u_trim (
		.clk_sys(clk_sys),
		.rst(rst),
		.rx_n(ir_rx_n),
		.trimmed_n(uart_rx_n)
	);
endmodule

// *** testbench/ir_codec_checker_properties.sv ***
/*
 * ir_codec_checker: port-level timing properties of the nibble codec.
 * assumes one clock domain, clk_sys, with async active-high rst.
 */
`timescale 1ns/100ps
module ir_codec_checker #(
	parameter int unsigned CARRIER_CLKS = 868
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// transmit side
	input wire ir_codec_pkg::tx_symbol_t tx_symbol,
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic ir_tx,
	// receive side
	input wire logic ir_rx_n,
	input wire ir_codec_pkg::rx_symbol_t rx_symbol,
	input wire logic rx_valid,
	input wire logic rx_frame_err,
	input wire logic uart_rx_n
);
	// the tick forces the registered emitter high in the clock after it, so the
	// high half is two clocks longer than the low half
	localparam int unsigned HI_RUN = CARRIER_CLKS / 2 + 1;
	localparam int unsigned LO_RUN = CARRIER_CLKS - HI_RUN;
	// run lengths of emitter levels and of receiver low
	logic [15:0] hi_len;
	logic [15:0] lo_len;
	logic [15:0] rx_lo;
	// first rise after reset has no aligned low run before it
	logic seen;

	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);

	// low counters saturate so a long idle cannot wrap
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			hi_len <= '0;
			lo_len <= '0;
			rx_lo <= '0;
			seen <= 1'b0;
		end else begin
			hi_len <= ir_tx ? hi_len + 16'h0001 : '0;
			lo_len <= ir_tx ? '0 : (&lo_len ? lo_len : lo_len + 16'h0001);
			rx_lo <= ir_rx_n ? '0 : (&rx_lo ? rx_lo : rx_lo + 16'h0001);
			if (ir_tx) seen <= 1'b1;
		end
	end

	// a symbol accepted by the encoder
	sequence s_take;
		tx_valid && tx_ready;
	endsequence
	// an error flag that drops again at once
	sequence s_err;
		rx_frame_err ##1 !rx_frame_err;
	endsequence

	a_carrier_half: assert property ($fell(ir_tx) |-> hi_len == HI_RUN)
		else $error("carrier high half has wrong length");
	a_gap_whole: assert property (
		$rose(ir_tx) && seen |-> lo_len % CARRIER_CLKS == LO_RUN)
		else $error("gap not whole carrier periods");
	a_ready_off: assert property (tx_ready |-> !ir_tx)
		else $error("emitter on while ready");
	a_ready_pulse: assert property (tx_ready |=> !tx_ready)
		else $error("ready longer than one cycle");
	a_take_burst: assert property (s_take |=> ir_tx)
		else $error("burst did not start after take");
	a_result_excl: assert property (!(rx_valid && rx_frame_err))
		else $error("valid and error together");
	a_symbol_hold: assert property ($changed(rx_symbol) |-> rx_valid)
		else $error("symbol changed without valid");
	a_header_nib: assert property (
		rx_valid && rx_symbol.header |-> rx_symbol.nibble == 4'h0)
		else $error("header carries a nibble");
	a_err_pulse: assert property (rx_frame_err |-> s_err)
		else $error("error flag longer than one cycle");
	a_uart_rise: assert property ($rose(ir_rx_n) |=> uart_rx_n)
		else $error("uart pulse stretched");
	a_trim_fall: assert property (
		$fell(uart_rx_n) |-> !ir_rx_n && rx_lo >= ir_codec_pkg::TRIM_CLKS)
		else $error("uart pulse not trimmed");
	a_uart_idle: assert property (
		ir_rx_n && $past(ir_rx_n) |-> uart_rx_n)
		else $error("uart low while receiver idle");
endmodule

bind ir_nibble_burst_gap_codec ir_codec_checker #(
	.CARRIER_CLKS(CARRIER_CLKS)
) i_chk (
	.clk_sys(clk_sys),
	.rst(rst),
	.tx_symbol(tx_symbol),
	.tx_valid(tx_valid),
	.tx_ready(tx_ready),
	.ir_tx(ir_tx),
	.ir_rx_n(ir_rx_n),
	.rx_symbol(rx_symbol),
	.rx_valid(rx_valid),
	.rx_frame_err(rx_frame_err),
	.uart_rx_n(uart_rx_n)
);

// *** testbench/ir_rx_model.sv ***
/*
 * ir_rx_model: behavioural receiver, turns the emitter drive into a
 * demodulated active-low level, with a bench override.
 * assumes the emitter drive is synchronous to clk_sys.
 */
`timescale 1ns/100ps
module ir_rx_model #(
	parameter int unsigned HOLD = 500
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// emitter drive from the codec
	input wire logic ir_tx,
	// bench override of the receiver level
	input wire logic raw_en,
	input wire logic raw_n,
	// demodulated output, low during a burst
	output wire logic ir_rx_n
);
	// clocks since the carrier was last high
	logic [15:0] quiet;
	// envelope, idles high like a real pull-up output
	logic env_n;

	// hold must outlast the 433-clock low half inside a burst; the
	// tail stretch is far under three carrier cycles
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			quiet <= 16'(HOLD);
			env_n <= 1'b1;
		end else if (ir_tx) begin
			quiet <= '0;
			env_n <= 1'b0;
		end else if (quiet < HOLD) begin
			quiet <= quiet + 16'h0001;
		end else begin
			env_n <= 1'b1;
		end
	end

	// bench drives raw levels for dead-zone cases
	assign ir_rx_n = raw_en ? raw_n : env_n;
endmodule

// *** testbench/test_ir_nibble_burst_gap_codec.sv ***
/*
 * test_ir_nibble_burst_gap_codec: self-checking bench, loops the
 * encoder through a receiver model and drives raw dead-zone levels.
 * assumes the codec runs at the package default carrier divider.
 */
`timescale 1ns/100ps
module test_ir_nibble_burst_gap_codec;
	localparam int C = ir_codec_pkg::CARRIER_CLKS;
	localparam int T = int'(ir_codec_pkg::TRIM_CLKS);
	// stimulus
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	ir_codec_pkg::tx_symbol_t tx_symbol = '0;
	logic tx_valid = 1'b0;
	logic raw_en = 1'b0;
	logic raw_n = 1'b1;
	// observed
	logic tx_ready, ir_tx, ir_rx_n, rx_valid, rx_frame_err, uart_rx_n;
	ir_codec_pkg::rx_symbol_t rx_symbol;
	int n_errors = 0;
	int n_tests = 0;
	// monitor state: run lengths, counts, captured results
	int lo = 0, nr = 0, ulo = 0, ulast = 0, ne = 0;
	int nq[$], gq[$];
	logic [4:0] rq[$];
	logic pv = 1'b0;
	// header, then nibbles from the first and last burst groups
	logic [4:0] seq[3] = '{5'h10, 5'h01, 5'h0e};

	always #10 clk_sys = ~clk_sys;

	ir_nibble_burst_gap_codec i_dut (
		.clk_sys(clk_sys),
		.rst(rst),
		.tx_symbol(tx_symbol),
		.tx_valid(tx_valid),
		.tx_ready(tx_ready),
		.ir_tx(ir_tx),
		.ir_rx_n(ir_rx_n),
		.rx_symbol(rx_symbol),
		.rx_valid(rx_valid),
		.rx_frame_err(rx_frame_err),
		.uart_rx_n(uart_rx_n)
	);
	ir_rx_model i_rx (
		.clk_sys(clk_sys),
		.rst(rst),
		.ir_tx(ir_tx),
		.raw_en(raw_en),
		.raw_n(raw_n),
		.ir_rx_n(ir_rx_n)
	);

	// carrier rises per burst, gap lengths, uart lows, results
	always @(posedge clk_sys) begin
		if (ir_tx === 1'b1 && !pv) begin
			nr++;
			if (lo > C / 2) gq.push_back(lo);
		end
		// idle stretch before the first burst has no rises to report
		if (ir_tx !== 1'b1 && lo == C - 1 && nr > 0) begin
			nq.push_back(nr);
			nr = 0;
		end
		lo = (ir_tx === 1'b1) ? 0 : lo + 1;
		pv = (ir_tx === 1'b1);
		if (uart_rx_n === 1'b0) ulo++;
		else if (ulo > 0) begin
			ulast = ulo;
			ulo = 0;
		end
		if (rx_valid === 1'b1) rq.push_back(rx_symbol);
		if (rx_frame_err === 1'b1) ne++;
	end

	// x never counts as inside the range
	task automatic chk(input logic [31:0] got, input int a, input int b);
		n_tests++;
		if ((got >= a) !== 1'b1 || (got <= b) !== 1'b1) begin
			n_errors++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, a);
		end
	endtask

	task automatic raw(input logic l, input int n);
		raw_n <= l;
		repeat (n) @(posedge clk_sys);
	endtask

	// expected burst and gap, in carrier cycles
	function automatic int bc(input logic [4:0] s);
		if (s[4]) return 30;
		return s[3:0] < 6 ? 6 : s[3:0] < 11 ? 12 : s[3:0] < 14 ? 18 : 24;
	endfunction
	function automatic int gc(input logic [4:0] s);
		if (s[4]) return 10;
		return 10 + 4 * (s[3:0] - (s[3:0] < 6 ? 0 : s[3:0] < 11 ? 6 :
			s[3:0] < 14 ? 11 : 14));
	endfunction

	// back to back symbols; a raw fall closes the last gap
	task automatic t_loop();
		int k;
		int g;
		nq.delete();
		gq.delete();
		rq.delete();
		tx_valid <= 1'b1;
		foreach (seq[i]) begin
			tx_symbol <= seq[i];
			k = 0;
			do begin
				@(posedge clk_sys);
				k++;
			end while (tx_ready !== 1'b1 && k < 40000);
			chk(tx_ready, 1, 1);
		end
		tx_valid <= 1'b0;
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
		end while (tx_ready !== 1'b1 && k < 40000);
		chk(tx_ready, 1, 1);
		raw_en <= 1'b1;
		raw_n <= 1'b0;
		k = 0;
		while (rq.size() < 3 && k < 100) begin
			@(posedge clk_sys);
			k++;
		end
		chk(rq.size(), 3, 3);
		foreach (seq[i]) begin
			chk(rq[i], seq[i], seq[i]);
			chk(nq[i], bc(seq[i]), bc(seq[i]));
		end
		for (int i = 0; i < 2; i++) begin
			g = gc(seq[i]) * C + C / 2;
			chk(gq[i + 1], g - 2, g + 2);
		end
	endtask

	// a pulse shorter than the trim never reaches the uart
	task automatic t_short();
		int e0;
		e0 = ne;
		ulast = 0;
		raw(1'b0, 1000);
		raw(1'b1, 50);
		chk(ne - e0, 1, 1);
		chk(ulast, 0, 0);
	endtask

	// 180 us burst falls between the first two bins
	task automatic t_burst_dead();
		int e0;
		e0 = ne;
		ulast = 0;
		raw(1'b0, 9000);
		raw(1'b1, 50);
		chk(ne - e0, 1, 1);
		chk(ulast, 9000 - T, 9000 - T);
	endtask

	// 208.4 us gap after a good burst, then reset in mid-burst
	task automatic t_gap_dead();
		int e0;
		e0 = ne;
		// 90 us burst is a good bin-0 burst; short tail keeps run brief
		raw(1'b0, 4500);
		raw(1'b1, 10420);
		raw(1'b0, 10);
		chk(ne - e0, 1, 1);
		chk(rq.size(), 3, 3);
		rst <= 1'b1;
		raw(1'b1, 3);
		rst <= 1'b0;
		@(posedge clk_sys);
		chk(rx_symbol, 0, 0);
		chk(ir_tx, 0, 0);
		chk(uart_rx_n, 1, 1);
	endtask

	task automatic tally_and_finish();
		$display("errors %0d, comparisons %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		t_loop();
		t_short();
		t_burst_dead();
		t_gap_dead();
		tally_and_finish();
	end

	// watchdog, just past the expected run of about 107k clocks
	initial begin
		repeat (112000) @(posedge clk_sys);
		n_errors++;
		tally_and_finish();
	end
endmodule
